//--- gpio_defines.svh
// constants for the six-port parallel i/o block: register byte
// offsets, reset values and field positions.
// assumes a 32-bit avalon-mm slave with byte addresses.
`ifndef GPIO_DEFINES_SVH
`define GPIO_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_PORT_A_OUT_LATCH         8'h00
`define OFS_PORT_A_PIN_READ          8'h04
`define OFS_PORT_A_SEGMENT_SELECT    8'h08
`define OFS_PORT_B_OUT_LATCH         8'h0C
`define OFS_PORT_B_PIN_READ          8'h10
`define OFS_PORT_C_OUT_LATCH         8'h14
`define OFS_PORT_C_PIN_READ          8'h18
`define OFS_PORT_C_OUTPUT_TYPE       8'h1C
`define OFS_PORT_D_OUT_LATCH         8'h20
`define OFS_PORT_D_PIN_READ          8'h24
`define OFS_PORT_D_SEGMENT_SELECT    8'h28
`define OFS_ANALOG_PORT_LATCH        8'h2C
`define OFS_ANALOG_PORT_DIRECTION    8'h30
`define OFS_CONVERTER_CONTROL_ONE    8'h34
`define OFS_PORT_F_OUT_LATCH         8'h38
`define OFS_PORT_F_PIN_READ          8'h3C
`define OFS_PORT_F_SEGMENT_SELECT    8'h40

// ----------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------
`define RST_LATCH8                   8'hFF
`define RST_LATCH3                   3'h7
`define RST_LATCH4                   4'hF
`define RST_CLEAR8                   8'h00
`define RST_CLEAR4                   4'h0
`define RST_ANALOG_INPUT_DIGITAL_DISABLE                    1'h1
`define BIT_ANALOG_INPUT_DIGITAL_DISABLE                    0

`endif

//--- gpio_pkg.sv
// types shared by the six-port parallel i/o block.
// assumes gpio_defines.svh sits in the include path.
`default_nettype none

package gpio_pkg;

	// ------------------------------------------------------------
	// one bit per pin of all six ports, 39 pins
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] a;
		logic [2:0] b;
		logic [3:0] c;
		logic [7:0] d;
		logic [7:0] e;
		logic [7:0] f;
	} port_pins_type;

	// bus access phases: idle, first state, second state
	typedef enum logic [1:0] {
		PH_IDLE,
		PH_S1,
		PH_S2
	} phase_type;

	// ------------------------------------------------------------
	// whole state of the port block
	// ------------------------------------------------------------
	typedef struct packed {
		phase_type     phase;
		logic          waitrequest;
		logic [31:0]   readdata;
		port_pins_type sample;
		logic [7:0]    a_latch;
		logic [7:0]    a_seg;
		logic [2:0]    b_latch;
		logic [3:0]    c_latch;
		logic [3:0]    c_type;
		logic [7:0]    d_latch;
		logic [7:0]    d_seg;
		logic [7:0]    e_latch;
		logic [7:0]    e_dir;
		logic          analog_input_digital_disable;
		logic [7:0]    f_latch;
		logic [7:0]    f_seg;
		port_pins_type drv_out;
		port_pins_type drv_oe_n;
		logic          external_interrupt_zero_prev;
		logic          external_interrupt_zero_pulse;
	} state_type;

endpackage

`default_nettype wire

//--- pin_sync.sv
// two-stage synchroniser for a group of pin levels.
// assumes inputs come from outside the mclk domain.
`default_nettype none

module pin_sync
#(
	parameter int WIDTH = 39
)
(
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             reset,
	// pin levels in and out
	input  wire logic [WIDTH-1:0] d,
	output var  logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_r;

	// first stage feeds only the second stage
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			meta_r <= '0;
			q      <= '0;
		end
		else
		begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule

`default_nettype wire

//--- multi_port_parallel_io.sv
// six parallel i/o ports with latches, pin reads, segment routing,
// output type control and an analog-capable port.
// assumes an avalon-mm master on mclk and pads that resolve the
// pin level from pin_out and pin_oe_n (low = driven).
// pins reach the logic only through the built-in synchroniser.
`include "gpio_defines.svh"
`default_nettype none

module multi_port_parallel_io
(
	// clock and reset
	input  wire logic                   mclk,
	input  wire logic                   reset,
	// avalon-mm slave
	input  wire logic [7:0]             address,
	input  wire logic                   read,
	input  wire logic                   write,
	input  wire logic [31:0]            writedata,
	input  wire logic [3:0]             byteenable,
	output var  logic [31:0]            readdata,
	output var  logic                   waitrequest,
	// system modes and lcd segment signals
	input  wire logic                   global_output_enable,
	input  wire logic                   stop_mode,
	input  wire logic                   dual_clock_mode,
	input  wire logic [7:0]             seg_a,
	input  wire logic [7:0]             seg_d,
	input  wire logic [7:0]             seg_f,
	// pins
	input  wire gpio_pkg::port_pins_type pin_in,
	output var  gpio_pkg::port_pins_type pin_out,
	output var  gpio_pkg::port_pins_type pin_oe_n,
	// interrupt event from stop_release_pin
	output var  logic                   external_interrupt_zero
);

	import gpio_pkg::*;

	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	// synchronised pins, whole state and its next value
	port_pins_type pin_q;
	state_type     s_r;
	state_type     s_nxt;
	logic [38:0]   pin_q_flat;

	// ------------------------------------------------------------
	// pin synchroniser
	// ------------------------------------------------------------
	// every pin passes two flops before any logic reads it, so the
	// snapshot, the edge detector and the read mux see one level;
	// the cost is two cycles between a pad change and read data,
	// which software never notices on a register access
	pin_sync #(
		.WIDTH (39)
	) u_pin_sync (
		.mclk  (mclk),
		.reset (reset),
		.d     (pin_in),
		.q     (pin_q_flat)
	);

	// the synchroniser works on a flat vector; restore the fields
	assign pin_q = port_pins_type'(pin_q_flat);

	// ------------------------------------------------------------
	// helper functions
	// ------------------------------------------------------------

	// the three segment-capable ports share one drive rule, so it
	// lives in two functions rather than in three copies of logic

	// released where latch is 1 and no segment, or outputs disabled
	function automatic logic [7:0] seg_port_oe_n(
		input logic [7:0] latch,
		input logic [7:0] seg,
		input logic       goe
	);
		seg_port_oe_n = {8{~goe}} | (~seg & latch);
	endfunction

	// segment signal replaces the latch on the pin, while the
	// latch keeps its stored value for later use
	function automatic logic [7:0] seg_port_out(
		input logic [7:0] latch,
		input logic [7:0] seg,
		input logic [7:0] seg_sig
	);
		seg_port_out = (seg & seg_sig) | (~seg & latch);
	endfunction

	// direction 0 with latch 0 marks an analog input; its pin may
	// sit at any voltage, so the digital path is cut to zero
	// analog port read: output bits give the latch, digital inputs
	// the pin, analog inputs and disabled inputs zero
	function automatic logic [7:0] analog_read(
		input logic [7:0] dir,
		input logic [7:0] latch,
		input logic [7:0] pins,
		input logic       analog_input_digital_disable
	);
		analog_read = (dir & latch)
			| (~dir & latch & pins & {8{~analog_input_digital_disable}});
	endfunction

	// register read multiplexer; bits above a port's width read 0
	// and unmapped offsets read as zero; pin reads give the snapshot
	// taken when the access started, not the live level
	function automatic logic [31:0] read_word(
		input logic [7:0]    adr,
		input state_type     s,
		input port_pins_type smp
	);
		logic [7:0] v;
		v = 8'h00;
		case (adr)
			`OFS_PORT_A_OUT_LATCH:      v = s.a_latch;
			`OFS_PORT_A_PIN_READ:       v = smp.a;
			`OFS_PORT_A_SEGMENT_SELECT: v = s.a_seg;
			`OFS_PORT_B_OUT_LATCH:      v = {5'h00, s.b_latch};
			`OFS_PORT_B_PIN_READ:       v = {5'h00, smp.b};
			`OFS_PORT_C_OUT_LATCH:      v = {4'h0, s.c_latch};
			`OFS_PORT_C_PIN_READ:       v = {4'h0, smp.c};
			`OFS_PORT_C_OUTPUT_TYPE:    v = {4'h0, s.c_type};
			`OFS_PORT_D_OUT_LATCH:      v = s.d_latch;
			`OFS_PORT_D_PIN_READ:       v = smp.d;
			`OFS_PORT_D_SEGMENT_SELECT: v = s.d_seg;
			`OFS_ANALOG_PORT_LATCH:
				v = analog_read(s.e_dir, s.e_latch, smp.e,
					s.analog_input_digital_disable);
			`OFS_ANALOG_PORT_DIRECTION: v = s.e_dir;
			`OFS_CONVERTER_CONTROL_ONE: v = {7'h00, s.analog_input_digital_disable};
			`OFS_PORT_F_OUT_LATCH:      v = s.f_latch;
			`OFS_PORT_F_PIN_READ:       v = smp.f;
			`OFS_PORT_F_SEGMENT_SELECT: v = s.f_seg;
			default:                    v = 8'h00;
		endcase
		read_word = {24'h000000, v};
	endfunction

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		s_nxt = s_r;

		// falling edge on stop_release_pin, driven or not; the edge
		// comes from the synchronised level, so a pulse shorter
		// than one cycle may be missed
		s_nxt.external_interrupt_zero_prev  = pin_q.b[0];
		s_nxt.external_interrupt_zero_pulse = s_r.external_interrupt_zero_prev & ~pin_q.b[0];

		// bus access sequence: idle takes the request and snapshots
		// the pins, the first state answers, the second state raises
		// waitrequest again; a request still held in the second
		// state is not taken twice because the phase is not idle
		case (s_r.phase)
			PH_IDLE:
			begin
				// snapshot pins on the edge that takes the request
				if (read || write)
				begin
					s_nxt.phase  = PH_S1;
					s_nxt.sample = pin_q;
				end
			end
			PH_S1:
			begin
				s_nxt.phase       = PH_S2;
				s_nxt.waitrequest = 1'b0;
				// read data is built from the state before this edge
				if (read)
				begin
					s_nxt.readdata = read_word(address, s_r,
						s_r.sample);
				end
				else if (byteenable[0])
				begin
					// latches take the value on leaving the first state;
					// pin-read and unmapped offsets fall through to
					// the default and change nothing
					case (address)
						`OFS_PORT_A_OUT_LATCH:
							s_nxt.a_latch = writedata[7:0];
						`OFS_PORT_A_SEGMENT_SELECT:
							s_nxt.a_seg = writedata[7:0];
						`OFS_PORT_B_OUT_LATCH:
							s_nxt.b_latch = writedata[2:0];
						`OFS_PORT_C_OUT_LATCH:
							s_nxt.c_latch = writedata[3:0];
						`OFS_PORT_C_OUTPUT_TYPE:
							s_nxt.c_type = writedata[3:0];
						`OFS_PORT_D_OUT_LATCH:
							s_nxt.d_latch = writedata[7:0];
						`OFS_PORT_D_SEGMENT_SELECT:
							s_nxt.d_seg = writedata[7:0];
						`OFS_ANALOG_PORT_LATCH:
							s_nxt.e_latch = writedata[7:0];
						`OFS_ANALOG_PORT_DIRECTION:
							s_nxt.e_dir = writedata[7:0];
						`OFS_CONVERTER_CONTROL_ONE:
							s_nxt.analog_input_digital_disable = writedata[`BIT_ANALOG_INPUT_DIGITAL_DISABLE];
						`OFS_PORT_F_OUT_LATCH:
							s_nxt.f_latch = writedata[7:0];
						`OFS_PORT_F_SEGMENT_SELECT:
							s_nxt.f_seg = writedata[7:0];
						default:
						begin
							s_nxt.f_seg = s_r.f_seg; // unmapped ignored
						end
					endcase
				end
			end
			PH_S2:
			begin
				// answer has been seen; back to idle
				s_nxt.phase       = PH_IDLE;
				s_nxt.waitrequest = 1'b1;
			end
			default:
			begin
				s_nxt.phase       = PH_IDLE;
				s_nxt.waitrequest = 1'b1;
			end
		endcase

		// synchronous reset values; reset comes last so it overrides
		// any access in flight, and the drive below is computed from
		// these values so the pins follow in the same edge
		if (reset)
		begin
			s_nxt.phase       = PH_IDLE;
			s_nxt.waitrequest = 1'b1;
			s_nxt.readdata    = 32'h00000000;
			s_nxt.sample      = '0;
			s_nxt.a_latch     = `RST_LATCH8;
			s_nxt.a_seg       = `RST_CLEAR8;
			s_nxt.b_latch     = `RST_LATCH3;
			s_nxt.c_latch     = `RST_LATCH4;
			s_nxt.c_type      = `RST_CLEAR4;
			s_nxt.d_latch     = `RST_LATCH8;
			s_nxt.d_seg       = `RST_CLEAR8;
			s_nxt.e_latch     = `RST_CLEAR8;
			s_nxt.e_dir       = `RST_CLEAR8;
			s_nxt.analog_input_digital_disable       = `RST_ANALOG_INPUT_DIGITAL_DISABLE;
			s_nxt.f_latch     = `RST_LATCH8;
			s_nxt.f_seg       = `RST_CLEAR8;
			s_nxt.external_interrupt_zero_prev   = 1'b0;
			s_nxt.external_interrupt_zero_pulse  = 1'b0;
		end

		// port a, d, f: latch 1 releases, segment drives; drive uses
		// the next latch values so a write reaches the pins in the
		// same edge as the latch
		s_nxt.drv_out.a  = seg_port_out(s_nxt.a_latch, s_nxt.a_seg,
			seg_a);
		s_nxt.drv_oe_n.a = seg_port_oe_n(s_nxt.a_latch, s_nxt.a_seg,
			global_output_enable);
		s_nxt.drv_out.d  = seg_port_out(s_nxt.d_latch, s_nxt.d_seg,
			seg_d);
		s_nxt.drv_oe_n.d = seg_port_oe_n(s_nxt.d_latch, s_nxt.d_seg,
			global_output_enable);
		s_nxt.drv_out.f  = seg_port_out(s_nxt.f_latch, s_nxt.f_seg,
			seg_f);
		s_nxt.drv_oe_n.f = seg_port_oe_n(s_nxt.f_latch, s_nxt.f_seg,
			global_output_enable);

		// port b: sink only; oscillator bits released in dual clock mode, stop input in stop mode.
		// the stop input ignores the output enable, and in stop mode
		// it is always released so that it can wake the part
		s_nxt.drv_out.b       = s_nxt.b_latch;
		s_nxt.drv_oe_n.b[2:1] = {2{~global_output_enable}}
			| s_nxt.b_latch[2:1] | {2{dual_clock_mode}};
		s_nxt.drv_oe_n.b[0]   = s_nxt.b_latch[0] | stop_mode;

		// port c: open-drain or push-pull per bit; an open-drain bit
		// with latch 1 is released and reads the external level
		s_nxt.drv_out.c  = s_nxt.c_latch;
		s_nxt.drv_oe_n.c = {4{~global_output_enable}}
			| (~s_nxt.c_type & s_nxt.c_latch);

		// analog port: driven only where direction is output; a pin
		// used as analog input must never have its direction set
		s_nxt.drv_out.e  = s_nxt.e_latch;
		s_nxt.drv_oe_n.e = {8{~global_output_enable}}
			| ~s_nxt.e_dir;
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	// one register for the whole state; reset is folded into the
	// next-state logic, so this process stays a plain copy and
	// every field shares one clock edge
	always_ff @(posedge mclk)
	begin
		s_r <= s_nxt;
	end

	// ------------------------------------------------------------
	// outputs, all straight from the state register
	// ------------------------------------------------------------
	// no output passes through logic after the register, so the
	// pads and the bus see clean levels that change only on the
	// rising edge of mclk
	assign readdata                = s_r.readdata;
	assign waitrequest             = s_r.waitrequest;
	assign pin_out                 = s_r.drv_out;
	assign pin_oe_n                = s_r.drv_oe_n;
	assign external_interrupt_zero = s_r.external_interrupt_zero_pulse;

endmodule

`default_nettype wire

//--- gpio_pins_model.sv
// board side of the port block: resolves each pin level.
// assumes released pins are pulled high unless the bench forces them.
`default_nettype none

module gpio_pins_model
(
	// drive from the block
	input  wire gpio_pkg::port_pins_type pin_out,
	input  wire gpio_pkg::port_pins_type pin_oe_n,
	// levels the bench forces on released pins
	input  wire gpio_pkg::port_pins_type ext_en,
	input  wire gpio_pkg::port_pins_type ext_val,
	// resolved level seen by the block
	output var  gpio_pkg::port_pins_type pin_level
);
	timeunit 1ns;
	timeprecision 100ps;
	import gpio_pkg::*;

	// driven pins follow the block, released ones the board or pull-up
	always_comb
	begin
		pin_level = port_pins_type'((~pin_oe_n & pin_out)
			| (pin_oe_n & ~ext_en) | (pin_oe_n & ext_en & ext_val));
	end
endmodule

`default_nettype wire

//--- multi_port_parallel_io_asserts.sv
// timing checks on the ports of the parallel port block.
// assumes synchronous active-high reset on mclk.
`default_nettype none

module multi_port_parallel_io_asserts
(
	// clock and reset
	input  wire logic                    mclk,
	input  wire logic                    reset,
	// avalon-mm slave
	input  wire logic [7:0]              address,
	input  wire logic                    read,
	input  wire logic                    write,
	input  wire logic [31:0]             writedata,
	input  wire logic [3:0]              byteenable,
	input  wire logic [31:0]             readdata,
	input  wire logic                    waitrequest,
	// modes, pins and interrupt
	input  wire logic                    global_output_enable,
	input  wire logic                    stop_mode,
	input  wire logic                    dual_clock_mode,
	input  wire gpio_pkg::port_pins_type pin_in,
	input  wire gpio_pkg::port_pins_type pin_oe_n,
	input  wire logic                    external_interrupt_zero
);
	import gpio_pkg::*;
	default clocking dc @(posedge mclk);
	endclocking
	default disable iff (reset);

	// ------------------------------------------------------------
	// sequences
	// ------------------------------------------------------------
	sequence b_write_done;
		write && !waitrequest && address == 8'h0C && byteenable[0];
	endsequence
	sequence b0_fall;
		$fell(pin_in.b[0]);
	endsequence
	sequence irq_seen;
		##[1:4] external_interrupt_zero;
	endsequence

	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	chk_read_answer: assert property ($rose(read) |-> ##2 !waitrequest)
		else $error("read not answered two edges after request");
	chk_write_answer: assert property ($rose(write) |->
		waitrequest [*2] ##1 !waitrequest)
		else $error("write not answered two edges after request");
	chk_wait_pulse: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low longer than one cycle");
	chk_b_drive: assert property (b_write_done |->
		!(global_output_enable && !stop_mode && !dual_clock_mode)
		|| pin_oe_n.b == writedata[2:0])
		else $error("port b drive not updated with write");
	chk_b_upper: assert property (read && !waitrequest &&
		(address == 8'h0C || address == 8'h10) |-> readdata[31:3] == 29'h0)
		else $error("port b upper read bits not zero");
	chk_c_upper: assert property (read && !waitrequest &&
		address inside {8'h14, 8'h18, 8'h1C} |-> readdata[31:4] == 28'h0)
		else $error("port c upper read bits not zero");
	chk_stop_release: assert property (stop_mode && $past(stop_mode)
		|-> pin_oe_n.b[0])
		else $error("stop release pin driven in stop mode");
	chk_osc_release: assert property (dual_clock_mode
		&& $past(dual_clock_mode) |-> pin_oe_n.b[2:1] == 2'h3)
		else $error("oscillator pins driven in dual clock mode");
	chk_goe_off: assert property (!global_output_enable
		&& !$past(global_output_enable) |-> pin_oe_n.a == 8'hFF
		&& pin_oe_n.c == 4'hF && pin_oe_n.e == 8'hFF && pin_oe_n.f == 8'hFF)
		else $error("pins driven with outputs disabled");
	chk_irq_edge: assert property (b0_fall |-> irq_seen)
		else $error("no interrupt after falling edge on pin b0");
	chk_irq_pulse: assert property (external_interrupt_zero |=>
		!external_interrupt_zero)
		else $error("interrupt pulse longer than one cycle");
endmodule

bind multi_port_parallel_io multi_port_parallel_io_asserts u_chk
(
	.mclk, .reset, .address, .read, .write, .writedata, .byteenable,
	.readdata, .waitrequest, .global_output_enable, .stop_mode,
	.dual_clock_mode, .pin_in, .pin_oe_n, .external_interrupt_zero
);

`default_nettype wire

//--- test_multi_port_parallel_io.sv
// self-checking bench for the six-port parallel i/o block.
// assumes the bus answer timing given with the block.
`default_nettype none

module test_multi_port_parallel_io;
	timeunit 1ns;
	timeprecision 100ps;
	import gpio_pkg::*;

	logic          mclk, reset, read, write, goe, stop_mode, dual_mode, irq;
	logic          waitrequest;
	logic [7:0]    address, seg_d;
	logic [3:0]    byteenable;
	logic [31:0]   writedata, readdata;
	port_pins_type pin_level, pin_out, pin_oe_n, ext_en, ext_val;
	int            err_total = 0, n_checks = 0, irq_cnt = 0;

	multi_port_parallel_io i_dut
	(
		.mclk, .reset, .address, .read, .write, .writedata, .byteenable,
		.readdata, .waitrequest, .global_output_enable(goe), .stop_mode,
		.dual_clock_mode(dual_mode), .seg_a(8'h00), .seg_d, .seg_f(8'h00),
		.pin_in(pin_level), .pin_out, .pin_oe_n,
		.external_interrupt_zero(irq)
	);
	gpio_pins_model i_pins
	(
		.pin_out, .pin_oe_n, .ext_en, .ext_val, .pin_level
	);

	// clock and interrupt pulse counter
	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	always @(posedge mclk)
		if (irq === 1'b1) irq_cnt++;

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask
	task automatic bus_op(input logic wr, input logic [7:0] adr,
		input logic [7:0] wd, output logic [31:0] rd);
		int n;
		n = 0;
		address <= adr;
		writedata <= {24'h000000, wd};
		write <= wr;
		read <= ~wr;
		@(posedge mclk);
		while (waitrequest !== 1'b0 && n < 20)
		begin
			n++;
			@(posedge mclk);
		end
		if (n == 20)
		begin
			err_total++;
			finish_test();
		end
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic wr(input logic [7:0] adr, input logic [7:0] d);
		logic [31:0] x;
		bus_op(1'b1, adr, d, x);
	endtask
	task automatic rd_chk(input logic [7:0] adr, input logic [31:0] e);
		logic [31:0] x;
		bus_op(1'b0, adr, 8'h00, x);
		check(x, e);
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		logic [7:0] adr [14] = '{8'h00, 8'h08, 8'h0C, 8'h14, 8'h1C, 8'h20,
			8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h40, 8'h44, 8'h04};
		logic [7:0] exp [14] = '{8'hFF, 8'h00, 8'h07, 8'h0F, 8'h00, 8'hFF,
			8'h00, 8'h00, 8'h00, 8'h01, 8'hFF, 8'h00, 8'h00, 8'hFF};
		for (int i = 0; i < 14; i++)
			rd_chk(adr[i], {24'h0, exp[i]});
		check(pin_oe_n.e, 8'hFF);
	endtask
	task automatic t_latch_pin();
		wr(8'h00, 8'h5A);
		check(pin_oe_n.a, 8'h5A);
		ext_en.a <= 8'hFF;
		ext_val.a <= 8'h0F;
		repeat (4) @(posedge mclk);
		rd_chk(8'h04, 32'h0A);
		wr(8'h04, 8'h00);
		byteenable <= 4'h0;
		wr(8'h00, 8'h00);
		byteenable <= 4'hF;
		rd_chk(8'h00, 32'h5A);
		ext_en.a <= 8'h00;
		wr(8'h00, 8'hFF);
	endtask
	task automatic t_port_c();
		wr(8'h14, 8'h05);
		check(pin_oe_n.c, 4'h5);
		wr(8'h1C, 8'h0F);
		check(pin_oe_n.c, 4'h0);
		check(pin_out.c, 4'h5);
		rd_chk(8'h1C, 32'h0F);
		wr(8'h14, 8'h0F);
		wr(8'h1C, 8'h00);
	endtask
	task automatic t_segment();
		seg_d <= 8'hA5;
		wr(8'h28, 8'h0F);
		wr(8'h20, 8'h3C);
		check(pin_oe_n.d, 8'h30);
		check(pin_out.d, 8'h35);
		rd_chk(8'h20, 32'h3C);
		wr(8'h28, 8'h00);
		wr(8'h20, 8'hFF);
	endtask
	task automatic t_analog();
		wr(8'h30, 8'h0F);
		wr(8'h2C, 8'h3C);
		check(pin_oe_n.e, 8'hF0);
		check(pin_out.e[3:0], 4'hC);
		rd_chk(8'h2C, 32'h0C);
		wr(8'h34, 8'h00);
		repeat (4) @(posedge mclk);
		rd_chk(8'h2C, 32'h3C);
		wr(8'h30, 8'h00);
	endtask
	task automatic t_modes();
		wr(8'h0C, 8'h00);
		repeat (6) @(posedge mclk);
		check(irq_cnt, 1);
		stop_mode <= 1'b1;
		repeat (3) @(posedge mclk);
		check(pin_oe_n.b[0], 1'b1);
		stop_mode <= 1'b0;
		dual_mode <= 1'b1;
		repeat (3) @(posedge mclk);
		check(pin_oe_n.b[2:1], 2'h3);
		dual_mode <= 1'b0;
		wr(8'h00, 8'h00);
		goe <= 1'b0;
		repeat (3) @(posedge mclk);
		check(pin_oe_n.a, 8'hFF);
		check(pin_oe_n.b, 3'h6);
		check(irq_cnt, 2);
		goe <= 1'b1;
		repeat (3) @(posedge mclk);
		wr(8'h00, 8'hFF);
		wr(8'h0C, 8'h07);
	endtask

	// main sequence and overall timeout
	initial
	begin
		{reset, read, write, goe, stop_mode, dual_mode} = 6'b100100;
		{address, seg_d, writedata, byteenable} = {16'h0, 32'h0, 4'hF};
		ext_en = '0;
		ext_val = '0;
		repeat (20) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		t_reset();
		t_latch_pin();
		t_port_c();
		t_segment();
		t_analog();
		t_modes();
		finish_test();
	end
	initial
	begin
		repeat (20000) @(posedge mclk);
		err_total++;
		finish_test();
	end
endmodule

`default_nettype wire
